// ==== rtl/uart_status_pkg.sv ====
// Package with register map, reset values and types of the status block.
package uart_status_pkg;

    // Register indices on the 5-bit register port.
    localparam logic [4:0] ADDR_RX_TX     = 5'h00;
    localparam logic [4:0] ADDR_INT_EN    = 5'h01;
    localparam logic [4:0] ADDR_ENH_FEAT  = 5'h02;
    localparam logic [4:0] ADDR_FIFO_CTRL = 5'h03;
    localparam logic [4:0] ADDR_MODEM_CTL = 5'h04;
    localparam logic [4:0] ADDR_LINE_STAT = 5'h05;
    localparam logic [4:0] ADDR_MODEM_STA = 5'h06;
    localparam logic [4:0] ADDR_SCRATCH   = 5'h07;
    localparam logic [4:0] ADDR_DIV_LOW   = 5'h08;
    localparam logic [4:0] ADDR_DIV_HIGH  = 5'h09;
    localparam logic [4:0] ADDR_DIV_FRAC  = 5'h0a;
    localparam logic [4:0] ADDR_DEV_ID    = 5'h0b;
    localparam logic [4:0] ADDR_DEV_REV   = 5'h0c;
    localparam logic [4:0] ADDR_RESUME_1  = 5'h0d;
    localparam logic [4:0] ADDR_RESUME_2  = 5'h0e;
    localparam logic [4:0] ADDR_PAUSE_1   = 5'h0f;
    localparam logic [4:0] ADDR_PAUSE_2   = 5'h10;

    // Field positions.
    localparam int EFR_ENH_BIT   = 4;
    localparam int EFR_ACTS_BIT  = 7;
    localparam int IER_MODEM_BIT = 3;
    localparam int MCR_LOOP_BIT  = 4;
    localparam int LSR_THRE_BIT  = 5;

    // Reset values; the identity codes are arbitrary.
    localparam logic [7:0] SCRATCH_RST  = 8'hff;
    localparam logic [7:0] DIV_LOW_RST  = 8'h01;
    localparam logic [7:0] DIV_HIGH_RST = 8'h00;
    localparam logic [7:0] DEV_ID_VAL   = 8'h5a;
    localparam logic [7:0] DEV_REV_VAL  = 8'h0a;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;

    localparam int RX_DEPTH = 16;

    typedef enum logic [1:0] {
        SAMPLE_16X = 2'b00,
        SAMPLE_8X  = 2'b01,
        SAMPLE_4X  = 2'b10
    } sample_rate_t;

    typedef enum logic [2:0] {
        MATCH_NONE   = 3'b000,
        MATCH_FIRST  = 3'b001,
        MATCH_SECOND = 3'b010,
        MATCH_EITHER = 3'b011,
        MATCH_BOTH   = 3'b100
    } rx_match_t;

    // One received character with its error tags.
    typedef struct packed {
        logic       brk;
        logic       frame_err;
        logic       parity_err;
        logic [7:0] data;
    } rx_entry_t;

    // Baud divisor: integer part and sixteenths.
    typedef struct packed {
        logic [15:0] whole;
        logic [3:0]  frac;
    } divisor_t;

endpackage : uart_status_pkg

// ==== rtl/uart_status_block.sv ====
// Status, modem status, divisor and flow select logic of one serial channel.
`timescale 1ns/1ps
module uart_status_block (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic [4:0]                 addr_i,
    input  wire logic [7:0]                 wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [7:0]                 rdata_o,
    input  wire logic                       rx_done_i,
    input  wire uart_status_pkg::rx_entry_t rx_char_i,
    input  wire logic                       tx_shift_load_i,
    input  wire logic                       tx_shift_empty_i,
    input  wire logic                       tx_fifo_empty_i,
    output logic                            tx_hold_wr_o,
    output logic      [7:0]                 tx_hold_data_o,
    output logic                            tx_stop_o,
    input  wire logic                       cts_n_i,
    input  wire logic                       dsr_n_i,
    input  wire logic                       ring_indicator_in_n_i,
    input  wire logic                       carrier_detect_in_n_i,
    output logic                            modem_irq_o,
    output uart_status_pkg::divisor_t       divisor_o,
    output uart_status_pkg::sample_rate_t   sample_rate_o,
    output logic      [1:0]                 tx_flow_sel_o,
    output uart_status_pkg::rx_match_t      rx_match_o,
    output logic      [7:0]                 modem_control_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [7:0]  ie_q, efr_q, fifo_ctl_q, mcr_q, scratch_q;
    logic [7:0]  dll_q, dlm_q, dld_q;
    logic [7:0]  res1_q, res2_q, pau1_q, pau2_q;
    logic [3:0]  pin_m_q, pin_s_q, stat_prev_q, delta_q;
    logic        overrun_q, break_seen_q, hold_empty_q;
    uart_status_pkg::rx_entry_t fifo_q [uart_status_pkg::RX_DEPTH];
    logic [3:0]  wptr_q, rptr_q;
    logic [4:0]  count_q;
    logic [3:0]  stat_now;
    logic [7:0]  lsr_now;
    logic        enh, push, pop, full, err_sum;
    uart_status_pkg::rx_entry_t head;

    // Byte write to one register index.
    function automatic logic wr_at(input logic [4:0] a);
        wr_at = wr_i && (addr_i == a);
    endfunction : wr_at

    // Merge a write with bits that stay frozen while enhanced is off.
    function automatic logic [7:0] keep(input logic [7:0] old,
                                        input logic [7:0] frozen);
        keep = (wdata_i & ~frozen) | (old & frozen);
    endfunction : keep

    // Receive matching decode of the flow selection.
    function automatic uart_status_pkg::rx_match_t
        match_of(input logic [3:0] s);
        case (s[1:0])
            2'b10:   match_of = uart_status_pkg::MATCH_FIRST;
            2'b01:   match_of = uart_status_pkg::MATCH_SECOND;
            2'b11:   match_of = (s[3] ^ s[2]) ?
                                uart_status_pkg::MATCH_EITHER :
                                uart_status_pkg::MATCH_BOTH;
            default: match_of = uart_status_pkg::MATCH_NONE;
        endcase
    endfunction : match_of

    assign enh = efr_q[uart_status_pkg::EFR_ENH_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Control registers.

    // Writes to the enhanced bits are dropped while enhanced is off, so
    // legacy software cannot disturb settings made earlier.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ie_q       <= uart_status_pkg::ZERO_BYTE;
            efr_q      <= uart_status_pkg::ZERO_BYTE;
            fifo_ctl_q <= uart_status_pkg::ZERO_BYTE;
            mcr_q      <= uart_status_pkg::ZERO_BYTE;
            dld_q      <= uart_status_pkg::ZERO_BYTE;
        end else begin
            if (wr_at(uart_status_pkg::ADDR_INT_EN)) begin
                ie_q <= keep(ie_q, enh ? 8'h00 : 8'hf0);
            end
            if (wr_at(uart_status_pkg::ADDR_MODEM_CTL)) begin
                mcr_q <= keep(mcr_q, enh ? 8'h00 : 8'he0);
            end
            if (wr_at(uart_status_pkg::ADDR_ENH_FEAT)) begin
                efr_q <= wdata_i;
            end
            if (wr_at(uart_status_pkg::ADDR_FIFO_CTRL)) begin
                fifo_ctl_q <= wdata_i;
            end
            if (wr_at(uart_status_pkg::ADDR_DIV_FRAC) && enh) begin
                dld_q <= {2'b00, wdata_i[5:0]};
            end
        end
    end

    // Divisor, scratch and flow characters.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scratch_q <= uart_status_pkg::SCRATCH_RST;
            dll_q     <= uart_status_pkg::DIV_LOW_RST;
            dlm_q     <= uart_status_pkg::DIV_HIGH_RST;
            res1_q    <= uart_status_pkg::ZERO_BYTE;
            res2_q    <= uart_status_pkg::ZERO_BYTE;
            pau1_q    <= uart_status_pkg::ZERO_BYTE;
            pau2_q    <= uart_status_pkg::ZERO_BYTE;
        end else begin
            if (wr_at(uart_status_pkg::ADDR_SCRATCH)) begin
                scratch_q <= wdata_i;
            end
            if (wr_at(uart_status_pkg::ADDR_DIV_LOW)) begin
                dll_q <= wdata_i;
            end
            if (wr_at(uart_status_pkg::ADDR_DIV_HIGH)) begin
                dlm_q <= wdata_i;
            end
            if (wr_at(uart_status_pkg::ADDR_RESUME_1)) begin
                res1_q <= wdata_i;
            end
            if (wr_at(uart_status_pkg::ADDR_RESUME_2)) begin
                res2_q <= wdata_i;
            end
            if (wr_at(uart_status_pkg::ADDR_PAUSE_1)) begin
                pau1_q <= wdata_i;
            end
            if (wr_at(uart_status_pkg::ADDR_PAUSE_2)) begin
                pau2_q <= wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive FIFO with per-byte error tags.

    // A break character is stored once; the rest of the same break is
    // swallowed until a normal character ends it.
    assign full = (count_q == 5'd16);
    assign pop  = rd_i && (addr_i == uart_status_pkg::ADDR_RX_TX)
                  && (count_q != 5'd0);
    assign push = rx_done_i && !full
                  && !(rx_char_i.brk && break_seen_q);
    assign head = fifo_q[rptr_q];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_q       <= 4'h0;
            rptr_q       <= 4'h0;
            count_q      <= 5'h00;
            break_seen_q <= 1'b0;
        end else begin
            if (push) begin
                fifo_q[wptr_q] <= rx_char_i;
                wptr_q         <= wptr_q + 4'h1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 4'h1;
            end
            count_q <= count_q + {4'h0, push} - {4'h0, pop};
            if (rx_done_i) begin
                break_seen_q <= rx_char_i.brk;
            end
        end
    end

    // Error summary over the occupied entries only.
    always_comb begin
        err_sum = 1'b0;
        for (int i = 0; i < uart_status_pkg::RX_DEPTH; i++) begin
            if ((5'(i) < count_q) &&
                (|fifo_q[4'(rptr_q + 4'(i))][10:8])) begin
                err_sum = 1'b1;
            end
        end
    end

    // Overrun stays until line status is read; a new overrun in the
    // read cycle wins over the clear.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overrun_q <= 1'b0;
        end else if (rx_done_i && full) begin
            overrun_q <= 1'b1;
        end else if (rd_i && addr_i == uart_status_pkg::ADDR_LINE_STAT) begin
            overrun_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit side.

    // Host write clears holding-empty; a shifter load sets it again.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_empty_q   <= 1'b1;
            tx_hold_wr_o   <= 1'b0;
            tx_hold_data_o <= uart_status_pkg::ZERO_BYTE;
        end else begin
            tx_hold_wr_o <= wr_at(uart_status_pkg::ADDR_RX_TX);
            if (wr_at(uart_status_pkg::ADDR_RX_TX)) begin
                hold_empty_q   <= 1'b0;
                tx_hold_data_o <= wdata_i;
            end else if (tx_shift_load_i) begin
                hold_empty_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modem inputs.

    // Two-stage synchroniser for the four modem pins.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_m_q <= 4'hf;
            pin_s_q <= 4'hf;
        end else begin
            pin_m_q <= {carrier_detect_in_n_i, ring_indicator_in_n_i,
                        dsr_n_i, cts_n_i};
            pin_s_q <= pin_m_q;
        end
    end

    // Bits 3:0 are carrier, ring, ready, clear status (active high).
    assign stat_now = mcr_q[uart_status_pkg::MCR_LOOP_BIT] ?
                      mcr_q[3:0] :
                      ~pin_s_q;

    // Change flags; an event in the read cycle survives the clear.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_prev_q <= 4'h0;
            delta_q     <= 4'h0;
        end else begin
            stat_prev_q <= stat_now;
            delta_q     <= (rd_i && addr_i == uart_status_pkg::ADDR_MODEM_STA
                            ? 4'h0 : delta_q)
                           | {stat_prev_q[3] ^ stat_now[3],
                              stat_prev_q[2] & ~stat_now[2],
                              stat_prev_q[1:0] ^ stat_now[1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and read data.

    // Line status assembled from the head entry and transmit state.
    always_comb begin
        lsr_now    = {err_sum, 1'b0, 1'b0, head.brk, head.frame_err,
                      head.parity_err, overrun_q, count_q != 5'd0};
        lsr_now[6] = (fifo_ctl_q[0] ? tx_fifo_empty_i : hold_empty_q)
                     && tx_shift_empty_i;
        lsr_now[uart_status_pkg::LSR_THRE_BIT] =
            fifo_ctl_q[0] ? tx_fifo_empty_i : hold_empty_q;
        if (count_q == 5'd0) begin
            lsr_now[4:2] = 3'b000;
        end
    end

    // Registered outputs; the auto stop waits for the current character
    // because the transmitter samples it only between characters.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            modem_irq_o     <= 1'b0;
            tx_stop_o       <= 1'b0;
            divisor_o       <= '0;
            sample_rate_o   <= uart_status_pkg::SAMPLE_16X;
            tx_flow_sel_o   <= 2'b00;
            rx_match_o      <= uart_status_pkg::MATCH_NONE;
            modem_control_o <= uart_status_pkg::ZERO_BYTE;
        end else begin
            modem_irq_o <= ie_q[uart_status_pkg::IER_MODEM_BIT]
                           && (delta_q != 4'h0);
            tx_stop_o   <= efr_q[uart_status_pkg::EFR_ACTS_BIT]
                           && pin_s_q[0];
            divisor_o   <= {dlm_q, dll_q, dld_q[3:0]};
            sample_rate_o <= dld_q[5] ? uart_status_pkg::SAMPLE_4X :
                             dld_q[4] ? uart_status_pkg::SAMPLE_8X :
                                        uart_status_pkg::SAMPLE_16X;
            tx_flow_sel_o <= efr_q[3:2];
            rx_match_o    <= match_of(efr_q[3:0]);
            modem_control_o <= mcr_q;
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= uart_status_pkg::ZERO_BYTE;
        end else if (rd_i) begin
            case (addr_i)
                uart_status_pkg::ADDR_RX_TX:     rdata_o <= head.data;
                uart_status_pkg::ADDR_INT_EN:    rdata_o <= ie_q;
                uart_status_pkg::ADDR_ENH_FEAT:  rdata_o <= efr_q;
                uart_status_pkg::ADDR_FIFO_CTRL: rdata_o <= fifo_ctl_q;
                uart_status_pkg::ADDR_MODEM_CTL: rdata_o <= mcr_q;
                uart_status_pkg::ADDR_LINE_STAT: rdata_o <= lsr_now;
                uart_status_pkg::ADDR_MODEM_STA: rdata_o <= {stat_now,
                                                             delta_q};
                uart_status_pkg::ADDR_SCRATCH:   rdata_o <= scratch_q;
                uart_status_pkg::ADDR_DIV_LOW:   rdata_o <= dll_q;
                uart_status_pkg::ADDR_DIV_HIGH:  rdata_o <= dlm_q;
                uart_status_pkg::ADDR_DIV_FRAC:  rdata_o <= dld_q;
                // Identity reads only with a zero divisor.
                uart_status_pkg::ADDR_DEV_ID:    rdata_o <=
                    ({dlm_q, dll_q} == 16'h0000) ?
                    uart_status_pkg::DEV_ID_VAL : 8'h00;
                uart_status_pkg::ADDR_DEV_REV:   rdata_o <=
                    ({dlm_q, dll_q} == 16'h0000) ?
                    uart_status_pkg::DEV_REV_VAL : 8'h00;
                uart_status_pkg::ADDR_RESUME_1:  rdata_o <= res1_q;
                uart_status_pkg::ADDR_RESUME_2:  rdata_o <= res2_q;
                uart_status_pkg::ADDR_PAUSE_1:   rdata_o <= pau1_q;
                uart_status_pkg::ADDR_PAUSE_2:   rdata_o <= pau2_q;
                default:                         rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule : uart_status_block

// ==== dv/uart_status_assertions.sv ====
// Port level checker for the status block.
`timescale 1ns/1ps
module uart_status_assertions (
    input wire logic                          clk_i,
    input wire logic                          rst_n_i,
    input wire logic [4:0]                    addr_i,
    input wire logic [7:0]                    wdata_i,
    input wire logic                          wr_i,
    input wire logic                          cts_n_i,
    input wire logic                          tx_hold_wr_o,
    input wire logic [7:0]                    tx_hold_data_o,
    input wire logic                          tx_stop_o,
    input wire uart_status_pkg::divisor_t     divisor_o,
    input wire uart_status_pkg::sample_rate_t sample_rate_o,
    input wire logic [1:0]                    tx_flow_sel_o,
    input wire logic [7:0]                    modem_control_o
);
    // Write strobes per register.
    wire wr_hold = wr_i && addr_i == uart_status_pkg::ADDR_RX_TX;
    wire wr_frac = wr_i && addr_i == uart_status_pkg::ADDR_DIV_FRAC;
    wire wr_enh  = wr_i && addr_i == uart_status_pkg::ADDR_ENH_FEAT;
    wire wr_mctl = wr_i && addr_i == uart_status_pkg::ADDR_MODEM_CTL;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Outputs must only move for their own register writes; the stop follows clear-to-send.
    a_hold_write_pulse: assert property (
        wr_hold |=> tx_hold_wr_o && tx_hold_data_o == $past(wdata_i))
        else $error("holding write not passed on");
    a_hold_pulse_cause: assert property (
        tx_hold_wr_o |-> $past(wr_hold))
        else $error("holding pulse without a write");
    a_sample_rate_legal: assert property (
        sample_rate_o != 2'b11)
        else $error("illegal sampling rate code");
    a_frac_change_cause: assert property (
        $changed(divisor_o.frac)
        |-> $past(wr_frac) || $past(wr_frac, 2) || $past(wr_frac, 3))
        else $error("fraction changed without a write");
    a_stop_needs_cts: assert property (
        tx_stop_o
        |-> $past(cts_n_i, 2) || $past(cts_n_i, 3) || $past(cts_n_i, 4))
        else $error("transmitter stopped with clear-to-send low");
    a_stop_resumes: assert property (
        (!cts_n_i) [*5] |-> !tx_stop_o)
        else $error("transmitter not resumed");
    a_flow_change_cause: assert property (
        $changed(tx_flow_sel_o) |-> $past(wr_enh) || $past(wr_enh, 2))
        else $error("flow select changed without a write");
    a_modem_ctl_cause: assert property (
        $changed(modem_control_o) |-> $past(wr_mctl) || $past(wr_mctl, 2))
        else $error("modem control changed without a write");
endmodule : uart_status_assertions

bind uart_status_block uart_status_assertions u_uart_status_assertions (
    .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .cts_n_i, .tx_hold_wr_o,
    .tx_hold_data_o, .tx_stop_o, .divisor_o, .sample_rate_o,
    .tx_flow_sel_o, .modem_control_o);

// ==== dv/modem_far_end.sv ====
// Far-end modem model driving the four active-low modem pins.
`timescale 1ns/1ps
module modem_far_end (
    input  wire logic       clk_i,
    input  wire logic [3:0] assert_i,
    output logic            cts_n_o,
    output logic            dsr_n_o,
    output logic            ri_n_o,
    output logic            cd_n_o
);
    // Pins idle high and move just after an edge.
    initial begin
        {cts_n_o, dsr_n_o, ri_n_o, cd_n_o} = 4'hf;
    end
    always @(posedge clk_i) begin
        cts_n_o <= ~assert_i[0];
        dsr_n_o <= ~assert_i[1];
        ri_n_o  <= ~assert_i[2];
        cd_n_o  <= ~assert_i[3];
    end
endmodule : modem_far_end

// ==== dv/testbench.sv ====
// Self-checking bench for the status block.
`timescale 1ns/1ps
module testbench;
    logic                          clk_i = 1'b0;
    logic                          rst_n_i = 1'b0;
    logic [4:0]                    addr_i = 5'h00;
    logic [7:0]                    wdata_i = 8'h00;
    logic                          wr_i = 1'b0;
    logic                          rd_i = 1'b0;
    logic                          rx_done_i = 1'b0;
    uart_status_pkg::rx_entry_t    rx_char_i = '0;
    logic                          tx_shift_load_i = 1'b0;
    logic                          tx_shift_empty_i = 1'b1;
    logic                          tx_fifo_empty_i = 1'b1;
    logic [3:0]                    mdm = 4'h0;
    logic                          cts_n_i, dsr_n_i, ring_indicator_in_n_i;
    logic                          carrier_detect_in_n_i;
    logic [7:0]                    rdata_o, tx_hold_data_o, modem_control_o;
    logic                          tx_hold_wr_o, tx_stop_o, modem_irq_o;
    logic [1:0]                    tx_flow_sel_o;
    uart_status_pkg::divisor_t     divisor_o;
    uart_status_pkg::sample_rate_t sample_rate_o;
    uart_status_pkg::rx_match_t    rx_match_o;
    int                            bad_count = 0, checks = 0;

    always #5 clk_i = ~clk_i;

    uart_status_block u_uart_status_block (
        .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .rx_done_i, .rx_char_i, .tx_shift_load_i, .tx_shift_empty_i,
        .tx_fifo_empty_i, .tx_hold_wr_o, .tx_hold_data_o, .tx_stop_o,
        .cts_n_i, .dsr_n_i, .ring_indicator_in_n_i, .carrier_detect_in_n_i,
        .modem_irq_o, .divisor_o, .sample_rate_o, .tx_flow_sel_o,
        .rx_match_o, .modem_control_o);

    modem_far_end u_modem_far_end (
        .clk_i, .assert_i(mdm), .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i),
        .ri_n_o(ring_indicator_in_n_i), .cd_n_o(carrier_detect_in_n_i));

    ////////////////////////////////////////////////////////////////////////
    // Shared bus cycles and comparison.
    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rdc(input logic [4:0] a, input logic [7:0] e,
                       input logic [7:0] m = 8'hff);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(20'(rdata_o & m), 20'(e));
    endtask : rdc
    task automatic push(input logic [10:0] c);
        @(posedge clk_i);
        rx_done_i <= 1'b1;
        rx_char_i <= c;
        @(posedge clk_i);
        rx_done_i <= 1'b0;
    endtask : push
    // Short forms for the registers that the scenarios visit most.
    task automatic ls(input logic [7:0] e, input logic [7:0] m = 8'h9f);
        rdc(uart_status_pkg::ADDR_LINE_STAT, e, m);
    endtask : ls
    task automatic ms(input logic [7:0] e);
        rdc(uart_status_pkg::ADDR_MODEM_STA, e);
    endtask : ms
    task automatic rx(input logic [7:0] e);
        rdc(uart_status_pkg::ADDR_RX_TX, e);
    endtask : rx
    task automatic ef(input logic [7:0] d);
        wr(uart_status_pkg::ADDR_ENH_FEAT, d);
    endtask : ef

    ////////////////////////////////////////////////////////////////////////
    // Reset values, identity gating and an unmapped index.
    task automatic t_reset;
        rdc(uart_status_pkg::ADDR_SCRATCH, 8'hff);
        rdc(uart_status_pkg::ADDR_DIV_LOW, 8'h01);
        rdc(uart_status_pkg::ADDR_DIV_FRAC, 8'h00);
        ms(8'h00);
        rdc(uart_status_pkg::ADDR_DEV_ID, 8'h00);
        wr(uart_status_pkg::ADDR_DIV_LOW, 8'h00);
        rdc(uart_status_pkg::ADDR_DEV_ID, uart_status_pkg::DEV_ID_VAL);
        rdc(uart_status_pkg::ADDR_DEV_REV, uart_status_pkg::DEV_REV_VAL);
        wr(uart_status_pkg::ADDR_SCRATCH, 8'h3c);
        rdc(uart_status_pkg::ADDR_SCRATCH, 8'h3c);
        wr(5'h1f, 8'h77);
        rdc(5'h1f, 8'h00);
    endtask : t_reset

    // Fraction gating, sampling codes, divisor sum and freezing.
    task automatic t_div;
        logic [7:0] fv [4] = '{8'h05, 8'h1a, 8'h23, 8'hf1};
        logic [1:0] sr [4] = '{2'b00, 2'b01, 2'b10, 2'b10};
        wr(uart_status_pkg::ADDR_DIV_FRAC, 8'h25);
        rdc(uart_status_pkg::ADDR_DIV_FRAC, 8'h00);
        ef(8'h10);
        for (int i = 0; i < 4; i++) begin
            wr(uart_status_pkg::ADDR_DIV_FRAC, fv[i]);
            rdc(uart_status_pkg::ADDR_DIV_FRAC, fv[i] & 8'h3f);
            chk(20'(sample_rate_o), 20'(sr[i]));
        end
        wr(uart_status_pkg::ADDR_DIV_LOW, 8'h34);
        wr(uart_status_pkg::ADDR_DIV_HIGH, 8'h12);
        cyc(2);
        chk(divisor_o, 20'h12341);
        ef(8'h00);
        wr(uart_status_pkg::ADDR_DIV_FRAC, 8'h00);
        rdc(uart_status_pkg::ADDR_DIV_FRAC, 8'h31);
        chk(divisor_o, 20'h12341);
    endtask : t_div

    // All flow selections, cleared in between.
    task automatic t_flow;
        logic [3:0] ev [8] = '{4'h0, 4'h8, 4'h2, 4'h1, 4'hb, 4'h7, 4'hf, 4'h3};
        logic [2:0] mv [8] = '{3'd0, 3'd0, 3'd1, 3'd2, 3'd3, 3'd3, 3'd4, 3'd4};
        for (int i = 0; i < 8; i++) begin
            ef(8'h10);
            ef({4'h1, ev[i]});
            cyc(2);
            chk(20'(tx_flow_sel_o), 20'(ev[i][3:2]));
            chk(20'(rx_match_o), 20'(mv[i]));
        end
    endtask : t_flow

    // Automatic stop and resume by the far end's clear-to-send line.
    task automatic t_cts;
        ef(8'h80);
        cyc(6);
        chk(20'(tx_stop_o), 20'h1);
        mdm <= 4'b0001;
        cyc(6);
        chk(20'(tx_stop_o), 20'h0);
        mdm <= 4'b0000;
        ef(8'h00);
        cyc(6);
        chk(20'(tx_stop_o), 20'h0);
        ms(8'h01);
    endtask : t_cts

    // Change flags, ring end, interrupt, read clear and loopback.
    task automatic t_modem;
        wr(uart_status_pkg::ADDR_INT_EN, 8'h08);
        mdm <= 4'b0001;
        cyc(6);
        chk(20'(modem_irq_o), 20'h1);
        ms(8'h11);
        ms(8'h10);
        chk(20'(modem_irq_o), 20'h0);
        mdm <= 4'b0101;
        cyc(6);
        ms(8'h50);
        mdm <= 4'b1011;
        cyc(6);
        ms(8'hbe);
        wr(uart_status_pkg::ADDR_INT_EN, 8'h00);
        mdm <= 4'b0000;
        cyc(6);
        chk(20'(modem_irq_o), 20'h0);
        ms(8'h0b);
        wr(uart_status_pkg::ADDR_MODEM_CTL, 8'h1c);
        cyc(4);
        chk(20'(modem_control_o), 20'h1c);
        ms(8'hc8);
        wr(uart_status_pkg::ADDR_MODEM_CTL, 8'h00);
        cyc(4);
        ms(8'h0c);
    endtask : t_modem

    // Tagged bytes, break swallowing, full FIFO and overrun.
    task automatic t_rx;
        push(11'h141);
        push(11'h242);
        push(11'h400);
        push(11'h400);
        push(11'h043);
        ls(8'h85);
        rx(8'h41);
        ls(8'h89);
        rx(8'h42);
        ls(8'h91);
        rx(8'h00);
        ls(8'h01);
        rx(8'h43);
        for (int i = 0; i < uart_status_pkg::RX_DEPTH; i++) begin
            push({3'b000, 8'(8'h10 + i)});
        end
        push(11'h499);
        ls(8'h03);
        ls(8'h01);
        for (int i = 0; i < uart_status_pkg::RX_DEPTH; i++) begin
            rx(8'(8'h10 + i));
        end
        ls(8'h00);
    endtask : t_rx

    // Holding-empty and idle flags, plain and in FIFO mode.
    task automatic t_tx;
        wr(uart_status_pkg::ADDR_RX_TX, 8'h55);
        #1;
        chk(20'(tx_hold_data_o), 20'h55);
        ls(8'h00, 8'h60);
        tx_shift_load_i  <= 1'b1;
        tx_shift_empty_i <= 1'b0;
        @(posedge clk_i);
        tx_shift_load_i <= 1'b0;
        ls(8'h20, 8'h60);
        tx_shift_empty_i <= 1'b1;
        ls(8'h60, 8'h60);
        wr(uart_status_pkg::ADDR_FIFO_CTRL, 8'h01);
        tx_fifo_empty_i <= 1'b0;
        ls(8'h00, 8'h60);
        tx_fifo_empty_i <= 1'b1;
        ls(8'h60, 8'h60);
    endtask : t_tx

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_div;
        t_flow;
        t_cts;
        t_modem;
        t_rx;
        t_tx;
        test_done;
    end

    // About 320 cycles are needed; allow over fifteen times that.
    initial begin
        #50us;
        bad_count++;
        test_done;
    end
endmodule : testbench
